/* File: dcke_consts.vh */
`ifndef DCKE_CONSTS_VH
`define DCKE_CONSTS_VH

`define DCKE_ST_IDLE      3'h0
`define DCKE_ST_ACTIVE    3'h1
`define DCKE_ST_PPD       3'h2
`define DCKE_ST_APD       3'h3
`define DCKE_ST_SREF      3'h4
`define DCKE_ST_BAD       3'h5

`define DCKE_CMD_MRS      3'h0
`define DCKE_CMD_REF      3'h1
`define DCKE_CMD_PRE      3'h2
`define DCKE_CMD_ACT      3'h3
`define DCKE_CMD_WR       3'h4
`define DCKE_CMD_RD       3'h5
`define DCKE_CMD_NOP      3'h7

`define DCKE_XSRD_CLKS    200
`define DCKE_CKE_MIN_CLKS 3
`define DCKE_MR_SLOWEXIT  12
`define DCKE_EMR_RTT_LO   2
`define DCKE_EMR_RTT_HI   6

`endif

/* File: dcke_ctrl_model.sv */
`default_nettype none
module dcke_ctrl_model (
    input  wire logic mclk,
    output logic      link_clk,
    output logic      cke,
    output logic      cs_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'h0;
        cke = 1'h1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        forever #200 link_clk = ~link_clk;
    end
    // pins move after the fall and stand over two rises
    task automatic issue(input logic [3:0] cmd, input logic ke);
        @(negedge link_clk);
        @(posedge mclk);
        cke <= ke;
        {cs_n, ras_n, cas_n, we_n} <= cmd;
        @(posedge link_clk);
    endtask
endmodule
`default_nettype wire

/* File: dcke_edge.v */
`default_nettype none
module dcke_edge (
    input  wire mclk,
    input  wire nrst,
    input  wire din,
    output reg  level_q,
    output reg  rise_q
);
    reg s1_q;
    reg s2_q;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            s1_q    <= din;
            s2_q    <= s1_q;
            level_q <= s2_q;
            rise_q  <= s2_q & ~level_q;
        end
    end
endmodule
`default_nettype wire

/* File: dcke_power.v */
`include "dcke_consts.vh"
`default_nettype none
// How it works
// - act on current cke, previous cke, state
// - self refresh only from all idle
// - termination off in self refresh
// - no refresh during power-down
// - commands ignored in low-power states
// - masked write beats are not written
// - mode bit selects fast or slow exit from active power-down
module dcke_power #(
    parameter XSNR_CLKS = 10,
    parameter XARD_CLKS = 2,
    parameter XARDS_CLKS = 6,
    parameter DW = 8
) (
    input  wire          mclk,
    input  wire          nrst,
    input  wire          link_clk,
    input  wire          cke,
    input  wire          cs_n,
    input  wire          ras_n,
    input  wire          cas_n,
    input  wire          we_n,
    input  wire          termination_control,
    input  wire          driver_calibration_mode,
    input  wire          op_busy,
    input  wire          banks_open,
    input  wire [13:0]   mode_reg_program,
    input  wire [13:0]   extended_mode_reg_one,
    input  wire          write_mask_input,
    input  wire [DW-1:0] wr_data,
    input  wire          wr_beat,
    output reg  [2:0]    state_q,
    output reg  [2:0]    cmd_q,
    output reg           cmd_valid_q,
    output reg           illegal_q,
    output reg           odt_active_q,
    output reg           refresh_allowed_q,
    output reg           read_allowed_q,
    output reg           exit_ready_q,
    output reg           wr_en_q,
    output reg  [DW-1:0] wr_data_q
);
    wire       clk_lvl;
    wire       clk_rise;
    reg  [4:0] pin_s1_q;
    reg  [4:0] pin_s2_q;
    reg  [DW+1:0] dat_s1_q;
    reg  [DW+1:0] dat_s2_q;
    reg        cke_prev_q;
    reg  [7:0] xsrd_q;
    reg  [7:0] xsnr_q;
    reg  [3:0] xard_q;
    reg  [1:0] hold_q;
    reg  [2:0] state_d;

    dcke_edge u_clk (
        .mclk    (mclk),
        .nrst    (nrst),
        .din     (link_clk),
        .level_q (clk_lvl),
        .rise_q  (clk_rise)
    );

    function [2:0] decode;
        input c;
        input r;
        input a;
        input w;
        begin
            if (c)
                decode = `DCKE_CMD_NOP;
            else
                decode = {r, a, w} == 3'h7 ? `DCKE_CMD_NOP :
                         {r, a, w} == 3'h0 ? `DCKE_CMD_MRS :
                         {r, a, w} == 3'h1 ? `DCKE_CMD_REF :
                         {r, a, w} == 3'h2 ? `DCKE_CMD_PRE :
                         {r, a, w} == 3'h3 ? `DCKE_CMD_ACT :
                         {r, a, w} == 3'h4 ? `DCKE_CMD_WR  :
                         {r, a, w} == 3'h5 ? `DCKE_CMD_RD  : 3'h6;
        end
    endfunction

    // pins sampled two flops deep; beat, mask and data ride in step with them
    // reset to cke high and deselect so an early edge sees an idle bus
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= 5'h1F;
            pin_s2_q <= 5'h1F;
            dat_s1_q <= {(DW+2){1'b0}};
            dat_s2_q <= {(DW+2){1'b0}};
        end else begin
            pin_s1_q <= {cke, cs_n, ras_n, cas_n, we_n};
            pin_s2_q <= pin_s1_q;
            dat_s1_q <= {wr_beat, write_mask_input, wr_data};
            dat_s2_q <= dat_s1_q;
        end
    end

    wire       cke_now = pin_s2_q[4];
    wire [2:0] cmd_now = decode(pin_s2_q[3], pin_s2_q[2], pin_s2_q[1], pin_s2_q[0]);
    wire       is_nop  = cmd_now == `DCKE_CMD_NOP;
    wire       low_pwr = state_q == `DCKE_ST_PPD || state_q == `DCKE_ST_APD ||
                         state_q == `DCKE_ST_SREF;
    wire       cke_chg = cke_now != cke_prev_q;
    wire       slow    = mode_reg_program[`DCKE_MR_SLOWEXIT];
    wire       rtt_on  = extended_mode_reg_one[`DCKE_EMR_RTT_LO] |
                         extended_mode_reg_one[`DCKE_EMR_RTT_HI];

    always @* begin
        state_d = state_q;
        case (state_q)
            `DCKE_ST_PPD, `DCKE_ST_APD, `DCKE_ST_SREF: begin
                if (cke_now) begin
                    if (is_nop)
                        state_d = banks_open ? `DCKE_ST_ACTIVE : `DCKE_ST_IDLE;
                    else
                        state_d = `DCKE_ST_BAD;
                end
            end
            `DCKE_ST_IDLE, `DCKE_ST_ACTIVE: begin
                if (!cke_now) begin
                    if (op_busy)
                        state_d = `DCKE_ST_BAD;
                    else if (is_nop)
                        state_d = banks_open ? `DCKE_ST_APD : `DCKE_ST_PPD;
                    else if (cmd_now == `DCKE_CMD_REF && !banks_open)
                        state_d = `DCKE_ST_SREF;
                    else
                        state_d = `DCKE_ST_BAD;
                end else
                    state_d = banks_open ? `DCKE_ST_ACTIVE : `DCKE_ST_IDLE;
            end
            `DCKE_ST_BAD:
                state_d = `DCKE_ST_BAD;
            default:
                state_d = `DCKE_ST_BAD;
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q           <= `DCKE_ST_IDLE;
            cke_prev_q        <= 1'b1;
            cmd_q             <= `DCKE_CMD_NOP;
            cmd_valid_q       <= 1'b0;
            illegal_q         <= 1'b0;
            odt_active_q      <= 1'b0;
            refresh_allowed_q <= 1'b1;
            read_allowed_q    <= 1'b1;
            exit_ready_q      <= 1'b1;
            xsrd_q            <= 8'h00;
            xsnr_q            <= 8'h00;
            xard_q            <= 4'h0;
            hold_q            <= 2'h0;
            wr_en_q           <= 1'b0;
            wr_data_q         <= {DW{1'b0}};
        end else begin
            cmd_valid_q <= 1'b0;
            wr_en_q     <= 1'b0;
            if (clk_rise) begin
                cke_prev_q <= cke_now;
                state_q    <= state_d;
                hold_q     <= cke_chg ? 2'h1 : (hold_q == 2'h3 ? hold_q : hold_q + 2'h1);
                if (cke_chg && hold_q != 2'h0 && hold_q < `DCKE_CKE_MIN_CLKS)
                    illegal_q <= 1'b1;
                if (state_d == `DCKE_ST_BAD)
                    illegal_q <= 1'b1;
                if (driver_calibration_mode && !cke_now)
                    illegal_q <= 1'b1;
                if (state_q == `DCKE_ST_PPD || state_q == `DCKE_ST_APD)
                    if (rtt_on && termination_control === 1'bx)
                        illegal_q <= 1'b1;
                if (!low_pwr && cke_now && cke_prev_q) begin
                    if (cmd_now == 3'h6)
                        illegal_q <= 1'b1;
                    if (xsnr_q != 8'h00 && !is_nop)
                        illegal_q <= 1'b1;
                    if (xsrd_q != 8'h00 && cmd_now == `DCKE_CMD_RD)
                        illegal_q <= 1'b1;
                    if (xard_q != 4'h0 && !is_nop)
                        illegal_q <= 1'b1;
                    cmd_q       <= cmd_now;
                    cmd_valid_q <= !is_nop;
                end
                if (state_q == `DCKE_ST_SREF && state_d != `DCKE_ST_SREF) begin
                    xsrd_q <= 8'd`DCKE_XSRD_CLKS;
                    xsnr_q <= XSNR_CLKS[7:0];
                end else begin
                    if (xsrd_q != 8'h00)
                        xsrd_q <= xsrd_q - 8'h01;
                    if (xsnr_q != 8'h00)
                        xsnr_q <= xsnr_q - 8'h01;
                end
                if (state_q == `DCKE_ST_APD && state_d == `DCKE_ST_ACTIVE)
                    xard_q <= slow ? XARDS_CLKS[3:0] : XARD_CLKS[3:0];
                else if (xard_q != 4'h0)
                    xard_q <= xard_q - 4'h1;
                odt_active_q      <= rtt_on && termination_control &&
                                     state_d != `DCKE_ST_SREF;
                refresh_allowed_q <= state_d != `DCKE_ST_PPD &&
                                     state_d != `DCKE_ST_APD;
            end
            read_allowed_q <= xsrd_q == 8'h00;
            exit_ready_q   <= xsnr_q == 8'h00 && xard_q == 4'h0;
            if (clk_rise && dat_s2_q[DW+1] && !low_pwr && !dat_s2_q[DW]) begin
                wr_en_q   <= 1'b1;
                wr_data_q <= dat_s2_q[DW-1:0];
            end
        end
    end

    wire unused_ok = clk_lvl;
endmodule
`default_nettype wire

/* File: dcke_power_assertions.sv */
`include "dcke_consts.vh"
`default_nettype none
module dcke_power_chk (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic [2:0] state_q,
    input wire logic [2:0] cmd_q,
    input wire logic       cmd_valid_q,
    input wire logic       illegal_q,
    input wire logic       odt_active_q,
    input wire logic       refresh_allowed_q,
    input wire logic       read_allowed_q,
    input wire logic       wr_en_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire logic sr = state_q == `DCKE_ST_SREF;
    wire logic pd = state_q == `DCKE_ST_PPD || state_q == `DCKE_ST_APD;
    property p_pulse; cmd_valid_q |=> !cmd_valid_q; endproperty
    property p_sticky; illegal_q |=> illegal_q; endproperty
    property p_sref_src; state_q == `DCKE_ST_ACTIVE |=> !sr; endproperty
    property p_pd_cmd; pd ##1 pd |-> !cmd_valid_q || cmd_q == `DCKE_CMD_NOP; endproperty
    property p_odt; sr [*2] |-> !odt_active_q; endproperty
    property p_noref; pd [*2] |-> !refresh_allowed_q; endproperty
    property p_wr; wr_en_q |=> !wr_en_q; endproperty
    property p_rd; sr ##1 (!sr && state_q != `DCKE_ST_BAD) |-> ##2 !read_allowed_q [*3]; endproperty
    a_pulse: assert property (p_pulse) else $error("command strobe too long");
    a_sticky: assert property (p_sticky) else $error("illegal flag cleared");
    a_sref_src: assert property (p_sref_src) else $error("self refresh from active");
    a_pd_cmd: assert property (p_pd_cmd) else $error("command taken in power-down");
    a_odt: assert property (p_odt) else $error("termination on in self refresh");
    a_noref: assert property (p_noref) else $error("refresh allowed in power-down");
    a_wr: assert property (p_wr) else $error("write strobe too long");
    a_rd: assert property (p_rd) else $error("read allowed right after exit");
    c_sref: cover property (sr);
    c_pd: cover property (pd);
    c_wr: cover property (wr_en_q);
endmodule
bind dcke_power dcke_power_chk i_dcke_power_chk (
    .mclk(mclk), .nrst(nrst), .state_q(state_q), .cmd_q(cmd_q),
    .cmd_valid_q(cmd_valid_q), .illegal_q(illegal_q), .odt_active_q(odt_active_q),
    .refresh_allowed_q(refresh_allowed_q), .read_allowed_q(read_allowed_q), .wr_en_q(wr_en_q)
);
`default_nettype wire

/* File: test_dcke_power.sv */
`include "dcke_consts.vh"
`default_nettype none
module test_dcke_power;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk, nrst, op_busy, banks_open, mask, beat;
    logic [13:0] mr, emr;
    logic [7:0] wdata, wr_last;
    wire        link_clk, cke, cs_n, ras_n, cas_n, we_n, cmd_valid_q, illegal_q, odt_active_q;
    wire        refresh_allowed_q, read_allowed_q, wr_en_q, exit_ready_q;
    wire [2:0]  state_q, cmd_q;
    wire [7:0]  wr_data_q;
    int         miscompares, compares, wr_cnt;
    dcke_ctrl_model i_dcke_ctrl_model (.mclk(mclk), .link_clk(link_clk), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
    dcke_power i_dcke_power (.mclk(mclk), .nrst(nrst), .link_clk(link_clk), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .termination_control(1'h1),
        .driver_calibration_mode(1'h0), .op_busy(op_busy), .banks_open(banks_open),
        .mode_reg_program(mr), .extended_mode_reg_one(emr), .write_mask_input(mask),
        .wr_data(wdata), .wr_beat(beat), .state_q(state_q), .cmd_q(cmd_q),
        .cmd_valid_q(cmd_valid_q), .illegal_q(illegal_q), .odt_active_q(odt_active_q),
        .refresh_allowed_q(refresh_allowed_q), .read_allowed_q(read_allowed_q),
        .exit_ready_q(exit_ready_q), .wr_en_q(wr_en_q), .wr_data_q(wr_data_q));
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wr_en_q) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= wr_data_q;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [3:0] cmd, input logic ke);
        i_dcke_ctrl_model.issue(cmd, ke);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic final_report;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_reset;
        chk(8'(state_q), 8'(`DCKE_ST_IDLE));
        chk(8'(cmd_q), 8'(`DCKE_CMD_NOP));
        chk(8'({illegal_q, refresh_allowed_q, read_allowed_q}), 8'h03);
        $display("reset test done");
    endtask
    task automatic t_mask;
        int n0;
        for (int m = 0; m < 2; m++) begin
            @(negedge link_clk);
            @(posedge mclk);
            n0 = wr_cnt;
            mask <= m[0];
            wdata <= 8'hA5 ^ 8'(m);
            beat <= 1'h1;
            @(posedge link_clk);
            repeat (2) @(posedge mclk);
            beat <= 1'h0;
            repeat (6) @(posedge mclk);
            chk(8'(wr_cnt - n0), m ? 8'h00 : 8'h01);
            if (m == 0)
                chk(wr_last, 8'hA5);
        end
        $display("mask test done");
    endtask
    task automatic t_pd;
        for (int b = 0; b < 2; b++) begin
            @(posedge mclk);
            banks_open <= b[0];
            step(b ? 4'h3 : 4'h7, 1'h1);
            repeat (2) step(4'h7, 1'h1);
            repeat (3) step(4'h7, 1'h0);
            chk(8'(state_q), b ? 8'(`DCKE_ST_APD) : 8'(`DCKE_ST_PPD));
            chk(8'(refresh_allowed_q), 8'h00);
            chk(8'(odt_active_q), 8'h01);
            step(4'h7, 1'h1);
            chk(8'(exit_ready_q), b ? 8'h00 : 8'h01);
            repeat (5) step(4'h7, 1'h1);
            chk(8'(exit_ready_q), 8'h01);
            chk(8'(state_q), b ? 8'(`DCKE_ST_ACTIVE) : 8'(`DCKE_ST_IDLE));
        end
        $display("power-down test done");
    endtask
    task automatic t_sref;
        @(posedge mclk);
        banks_open <= 1'h0;
        step(4'h2, 1'h1);
        chk(8'(cmd_q), 8'(`DCKE_CMD_PRE));
        repeat (2) step(4'h7, 1'h1);
        step(4'h1, 1'h0);
        repeat (2) step(4'h7, 1'h0);
        chk(8'(state_q), 8'(`DCKE_ST_SREF));
        chk(8'(odt_active_q), 8'h00);
        step(4'h7, 1'h1);
        chk(8'(state_q), 8'(`DCKE_ST_IDLE));
        chk(8'(read_allowed_q), 8'h00);
        repeat (94) step(4'h7, 1'h1);
        chk(8'(read_allowed_q), 8'h00);
        repeat (8) step(4'h7, 1'h1);
        chk(8'(read_allowed_q), 8'h01);
        chk(8'(illegal_q), 8'h00);
        $display("self refresh test done");
    endtask
    task automatic t_illegal;
        @(posedge mclk);
        op_busy <= 1'h1;
        step(4'h7, 1'h0);
        @(posedge mclk);
        op_busy <= 1'h0;
        repeat (2) step(4'h7, 1'h0);
        repeat (3) step(4'h7, 1'h1);
        chk(8'(illegal_q), 8'h01);
        $display("illegal entry test done");
    endtask
    initial begin
        {nrst, op_busy, banks_open, mask, beat, wr_cnt, wr_last} = '0;
        {mr, emr, wdata} = {14'h1000, 14'h0004, 8'h00};
        repeat (16) @(posedge mclk);
        nrst <= 1'h1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        t_reset;
        t_mask;
        t_pd;
        t_sref;
        t_illegal;
        final_report;
    end
    initial begin
        #400000;
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire
